// ===== hdl/rco_pkg.sv
// Purpose: Constants for the reference clock output unit
// Assumes: Registers reached over classic Wishbone, 32-bit data, word per register
// Notes:   Register byte address is four times its index
//
// How it works
// - Three-bit source code picks one of five oscillator inputs; codes five-seven reserved.
// - Output starts only on a source rising edge, so no runt pulse.
// - Clearing enable forces the output low on the next clock.
// - Divider and duty writes accepted while enabled; glitches possible.
// - Output is the source divided by one to one hundred twenty-eight.
// - Divided output high for zero, quarter, half or three quarters of period.
// - Undivided output follows source at half duty; duty code zero holds low.
// - In sleep the output runs except when the system clock is source.
// - Same clock goes to the pin and to the internal peripheral net.
// - Divider code n divides by two to the power n.
// - Divided, duty code three, two, one, zero gives 75, 50, 25, 0 percent.
package rco_pkg;
  localparam int          ADR_W          = 14;
  localparam int          DAT_W          = 32;
  localparam logic [11:0] CTRL_IDX       = 12'hF34;
  localparam logic [11:0] SRC_IDX        = 12'hF35;
  localparam logic [11:0] STAT_IDX       = 12'hF36;
  localparam int          EN_BIT         = 7;
  localparam int          DC_LSB         = 3;
  localparam int          DIV_LSB        = 0;
  localparam logic [7:0]  CTRL_RESET     = 8'h10;
  localparam logic [2:0]  SRC_RESET      = 3'h0;
  localparam int          NUM_SRC        = 5;
  localparam logic [2:0]  SRC_SYS_OSC    = 3'h0;
  localparam logic [2:0]  SRC_HF_INT     = 3'h1;
  localparam logic [2:0]  SRC_LF_INT     = 3'h2;
  localparam logic [2:0]  SRC_MID_INT    = 3'h3;
  localparam logic [2:0]  SRC_SECONDARY  = 3'h4;
  localparam logic [1:0]  DC_ZERO        = 2'h0;
  localparam int          PHASE_W        = 8;
endpackage : rco_pkg

// ===== hdl/rco_sync.sv
// Purpose: Two-flop synchroniser with edge detection for oscillator inputs
// Assumes: Inputs are square waves far slower than half of clk_i
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module rco_sync #(
  parameter int W = 5
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] in_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] edge_o
);
  logic [W-1:0] meta;
  logic [W-1:0] stable;
  logic [W-1:0] last;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta   <= '0;
      stable <= '0;
      last   <= '0;
    end
    else
    begin
      meta   <= in_i;
      stable <= meta;
      last   <= stable;
    end
  end

  assign level_o = stable;
  assign rise_o  = stable & ~last;
  assign edge_o  = stable ^ last;
endmodule // rco_sync
`default_nettype wire

// ===== hdl/rco_top.sv
// Purpose: Reference clock output unit with Wishbone register access
// Assumes: Oscillator inputs sampled on clk_i, one bit per source code
// Notes:   Output is rebuilt from sampled edges, so it is clk_i-quantised
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
module rco_top (
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       cyc_i,
  input  wire logic                       stb_i,
  input  wire logic                       we_i,
  input  wire logic [rco_pkg::ADR_W-1:0]  adr_i,
  input  wire logic [3:0]                 sel_i,
  input  wire logic [rco_pkg::DAT_W-1:0]  dat_i,
  output logic      [rco_pkg::DAT_W-1:0]  dat_o,
  output logic                            ack_o,
  input  wire logic [rco_pkg::NUM_SRC-1:0] osc_clk_i,
  input  wire logic                       sleep_i,
  output logic                            ref_clock_output_pin_o,
  output logic                            ref_clock_internal_o
);
  import rco_pkg::*;

  logic [7:0]         ref_clock_control;
  logic [2:0]         ref_clock_source_select;
  logic               enable;
  logic [1:0]         duty_select;
  logic [2:0]         div_sel;
  logic [NUM_SRC-1:0] osc_level;
  logic [NUM_SRC-1:0] osc_rise;
  logic [NUM_SRC-1:0] osc_edge;
  logic               src_level;
  logic               src_rise;
  logic               src_edge;
  logic               src_valid;
  logic               stop;
  logic               armed;
  logic [PHASE_W-1:0] phase;
  logic               next_armed;
  logic [PHASE_W-1:0] next_phase;
  logic               next_out;
  logic [PHASE_W-1:0] last_phase;
  logic [PHASE_W:0]   high_len;
  logic [11:0]        reg_idx;
  logic               req;
  logic               wr_ctrl;
  logic               wr_src;

  assign enable      = ref_clock_control[EN_BIT];
  assign duty_select = ref_clock_control[DC_LSB +: 2];
  assign div_sel     = ref_clock_control[DIV_LSB +: 3];

  rco_sync #(
    .W (NUM_SRC)
  ) u_rco_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .in_i    (osc_clk_i),
    .level_o (osc_level),
    .rise_o  (osc_rise),
    .edge_o  (osc_edge)
  );

  // Source mux; reserved codes select nothing
  always_comb
  begin
    src_valid = (ref_clock_source_select < 3'(NUM_SRC));
    src_level = 1'b0;
    src_rise  = 1'b0;
    src_edge  = 1'b0;
    if (src_valid)
    begin
      src_level = osc_level[ref_clock_source_select];
      src_rise  = osc_rise[ref_clock_source_select];
      src_edge  = osc_edge[ref_clock_source_select];
    end
  end

  // System clock stops in sleep, other oscillators keep running
  assign stop = !enable || !src_valid
              || (sleep_i && ref_clock_source_select == SRC_SYS_OSC);

  // Phase counts half periods of the source: 2*N per output period
  assign last_phase = PHASE_W'((9'h002 << div_sel) - 9'h001);
  assign high_len   = 9'(({7'h00, duty_select} << div_sel) >> 1);

  always_comb
  begin
    next_armed = armed;
    next_phase = phase;
    if (stop)
    begin
      next_armed = 1'b0;
      next_phase = '0;
    end
    else if (!armed)
    begin
      // Arming on a rising edge keeps the first pulse whole
      if (src_rise)
      begin
        next_armed = 1'b1;
        next_phase = '0;
      end
    end
    else if (src_edge)
    begin
      next_phase = (phase == last_phase) ? '0 : phase + 1'b1;
    end
    if (div_sel == 3'h0)
      next_out = next_armed && duty_select != DC_ZERO && src_level;
    else
      next_out = next_armed && ({1'b0, next_phase} < high_len);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      armed <= 1'b0;
      phase <= '0;
    end
    else
    begin
      armed <= next_armed;
      phase <= next_phase;
    end
  end

  // Both copies from flops so peripherals see exactly the pin clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_clock_output_pin_o <= 1'b0;
      ref_clock_internal_o   <= 1'b0;
    end
    else
    begin
      ref_clock_output_pin_o <= next_out;
      ref_clock_internal_o   <= next_out;
    end
  end

  // Wishbone slave: one wait state, unmapped reads zero
  assign reg_idx = adr_i[ADR_W-1:2];
  assign req     = cyc_i && stb_i && !ack_o;
  assign wr_ctrl = req && we_i && sel_i[0] && reg_idx == CTRL_IDX;
  assign wr_src  = req && we_i && sel_i[0] && reg_idx == SRC_IDX;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= req;
  end

  // No lockout while enabled; software must avoid live changes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ref_clock_control <= CTRL_RESET;
    else if (wr_ctrl)
      ref_clock_control <= dat_i[7:0] & 8'h9F;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ref_clock_source_select <= SRC_RESET;
    else if (wr_src)
      ref_clock_source_select <= dat_i[2:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= '0;
    else if (req && !we_i)
    begin
      if (reg_idx == CTRL_IDX)
        dat_o <= {24'h000000, ref_clock_control};
      else if (reg_idx == SRC_IDX)
        dat_o <= {29'h00000000, ref_clock_source_select};
      else if (reg_idx == STAT_IDX)
        dat_o <= {30'h00000000, ref_clock_output_pin_o, armed};
      else
        dat_o <= '0;
    end
    else
      dat_o <= '0;
  end

  stop_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stop |=> !ref_clock_output_pin_o) else $error("output not low when stopped");

  sleep_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
    enable && sleep_i && ref_clock_source_select == SRC_SYS_OSC |=> !armed && phase == '0)
    else $error("system clock source ran in sleep");

  reserved_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ref_clock_source_select > SRC_SECONDARY |=> !ref_clock_output_pin_o)
    else $error("reserved source produced output");

  // Live register writes may glitch the output, so they excuse a rise
  clean_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ref_clock_output_pin_o)
    |-> $past(src_edge) || $past(wr_ctrl, 2) || $past(wr_src, 2))
    else $error("output rose without a source edge");

  pin_internal_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ref_clock_output_pin_o == ref_clock_internal_o)
    else $error("pin and internal clocks differ");

  duty_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    duty_select == DC_ZERO ##1 duty_select == DC_ZERO |-> !ref_clock_output_pin_o)
    else $error("duty zero output went high");

  undiv_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    armed && !stop && div_sel == 3'h0 && duty_select != DC_ZERO
    |=> ref_clock_output_pin_o == $past(src_level))
    else $error("undivided output not following source");

  phase_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    armed && !stop && src_edge && phase == last_phase |=> phase == '0)
    else $error("phase did not wrap at period end");

  half_duty_a: assert property (@(posedge clk_i) disable iff (rst_i)
    armed && !stop && div_sel == 3'h1 && duty_select == 2'h2 && src_rise && phase == 8'h03
    |=> ref_clock_output_pin_o) else $error("half duty divide-by-two not high");

  idle_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !enable |=> !armed && phase == '0) else $error("counters not held while off");

  live_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && enable |=> div_sel == $past(dat_i[2:0]) && duty_select == $past(dat_i[4:3]))
    else $error("control write ignored while enabled");

  bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("wishbone ack timing wrong");

  arm_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(armed)
    |-> $past(src_rise) && $past(enable) && $past(src_valid))
    else $error("armed without a source rising edge");

  first_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !armed && !stop && src_rise && duty_select != DC_ZERO
    |=> ref_clock_output_pin_o)
    else $error("first pulse after start missing");

  disable_now_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl && !dat_i[EN_BIT]
    |-> ##2 !ref_clock_output_pin_o)
    else $error("output not stopped after disable write");

  phase_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    armed && !stop && src_edge && phase != last_phase
    |=> phase == $past(phase) + 8'h01)
    else $error("phase did not advance on source edge");

  phase_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    armed && !stop && !src_edge |=> $stable(phase))
    else $error("phase moved without source edge");

  div_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
    div_sel == 3'h7
    |-> last_phase == 8'hFF && high_len == {1'b0, duty_select, 6'h00})
    else $error("divide by 128 decode wrong");

  div_two_a: assert property (@(posedge clk_i) disable iff (rst_i)
    div_sel == 3'h1
    |-> last_phase == 8'h03 && high_len == {7'h00, duty_select})
    else $error("divide by two duty decode wrong");

  stopped_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !armed |-> phase == '0 && !ref_clock_output_pin_o)
    else $error("idle unit not at period start");

  sleep_run_a: assert property (@(posedge clk_i) disable iff (rst_i)
    enable && src_valid && sleep_i && ref_clock_source_select != SRC_SYS_OSC
    |-> !stop)
    else $error("sleep stopped a running oscillator source");

  reserved_disarm_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ref_clock_source_select > SRC_SECONDARY |=> !armed)
    else $error("reserved source left unit armed");

  src_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_src |=> ref_clock_source_select == $past(dat_i[2:0]))
    else $error("source select write lost");

  period_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    armed && !stop && div_sel != 3'h0 && duty_select != DC_ZERO
    && src_edge && phase == last_phase
    |=> ref_clock_output_pin_o)
    else $error("divided period did not start high");

  read_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == '0)
    else $error("read data outside ack cycle");

  ctrl_pad_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ref_clock_control[6:5] == 2'h0)
    else $error("unused control bits not zero");
endmodule // rco_top
`default_nettype wire

// ===== tb/rco_osc_model.sv
// Purpose: Oscillator sources for the reference clock unit
// Assumes: Source n toggles every 4+n clk_i cycles
// Notes:   Exact half periods keep the expected pulse widths whole cycles
`timescale 1ns/1ps
`default_nettype none
module rco_osc_model (
  input  wire logic       clk_i,
  output logic      [4:0] osc_o
);
  logic [4:0] osc = 5'h00;
  int         cnt [5] = '{default: 0};
  assign osc_o = osc;
  // Bit n stands for source code n
  always @(posedge clk_i)
  begin
    for (int k = 0; k < 5; k++)
    begin
      if (cnt[k] == 3 + k)
      begin
        cnt[k]   <= 0;
        osc[k]   <= ~osc[k];
      end
      else
        cnt[k] <= cnt[k] + 1;
    end
  end
endmodule // rco_osc_model
`default_nettype wire

// ===== tb/reference_clock_output_bench.sv
// Purpose: Self-checking bench for the reference clock unit
// Assumes: Wishbone master with ack one cycle after the taking edge
// Notes:   Pulse widths counted in clk_i cycles at the pin
`timescale 1ns/1ps
`default_nettype none
module reference_clock_output_bench;
  import rco_pkg::*;
  logic             clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic             sleep = 1'b0, ack_o, pin, intl;
  logic [3:0]       sel = 4'h0;
  logic [4:0]       osc;
  logic [ADR_W-1:0] adr = '0;
  logic [DAT_W-1:0] dat = '0, dat_o;
  logic [31:0]      exp_q [$];
  int               num_errors = 0, samples_checked = 0, seed = 87755;
  initial forever #20 clk_i = ~clk_i;
  rco_top u_rco_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .osc_clk_i(osc),
    .sleep_i(sleep), .ref_clock_output_pin_o(pin), .ref_clock_internal_o(intl));
  rco_osc_model u_rco_osc_model (.clk_i(clk_i), .osc_o(osc));
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    samples_checked++;
    if (seen !== expd)
    begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic conclude();
    if (num_errors == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Only the master side waits on ack; the cycle after release stays idle
  task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d,
                    input logic [7:0] expd);
    if (!w) exp_q.push_back({24'h000000, expd});
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= 4'hF;
    adr <= {idx, 2'b00};
    dat <= {24'h000000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic low_for(input int n);
    int h;
    h = 0;
    repeat (n)
    begin
      @(posedge clk_i);
      if (pin !== 1'b0) h++;
    end
    check(h, 0);
  endtask
  task automatic meas(input int hi_e, input int per_e);
    int n, h, p;
    n = 0;
    h = 0;
    // Skip a pulse already under way; only whole pulses are measured
    while (pin === 1'b1 && n < 5000)
    begin
      @(posedge clk_i);
      n++;
    end
    while (pin !== 1'b1 && n < 5000)
    begin
      @(posedge clk_i);
      n++;
    end
    while (pin === 1'b1 && h < 5000)
    begin
      @(posedge clk_i);
      h++;
    end
    p = h;
    while (pin !== 1'b1 && p < 5000)
    begin
      @(posedge clk_i);
      p++;
    end
    check(h, hi_e);
    check(p, per_e);
  endtask
  // Configure while stopped, then start, as software is advised to do
  task automatic run(input int s, input int d, input int dc);
    int nd, hp;
    nd = 1 << d;
    hp = 4 + s;
    wb(1'b1, CTRL_IDX, {3'b000, dc[1:0], d[2:0]}, 8'h00);
    wb(1'b1, SRC_IDX, s[7:0], 8'h00);
    wb(1'b1, CTRL_IDX, {3'b100, dc[1:0], d[2:0]}, 8'h00);
    if (dc == 0 || s > 4 || (sleep && s == 0))
    begin
      low_for(300);
      wb(1'b0, STAT_IDX, 8'h00, {7'h00, s < 5 && !(sleep && s == 0)});
    end
    else
      meas(d == 0 ? hp : nd * dc / 2 * hp, 2 * nd * hp);
  endtask
  always @(posedge clk_i)
  begin
    if (ack_o === 1'b1 && we === 1'b0) check(dat_o, exp_q.pop_front());
    if (!rst_i) check(intl, pin);
  end
  initial
  begin
    #4000000;
    num_errors++;
    conclude();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    low_for(300);
    wb(1'b0, CTRL_IDX, 8'h00, CTRL_RESET);
    wb(1'b0, SRC_IDX, 8'h00, {5'h00, SRC_RESET});
    wb(1'b0, 12'h100, 8'h00, 8'h00);
    wb(1'b1, CTRL_IDX, 8'h7F, 8'h00);
    wb(1'b0, CTRL_IDX, 8'h00, 8'h1F);
    run(5, 1, 2);
    for (int d = 0; d < 8; d++)
      for (int dc = 0; dc < 4; dc++)
        run($unsigned($random(seed)) % 5, d, dc);
    run(1, 3, 2);
    wb(1'b1, CTRL_IDX, 8'h1A, 8'h00);
    check(pin, 1'b0);
    run(1, 1, 2);
    wb(1'b1, CTRL_IDX, 8'h93, 8'h00);
    repeat (100) @(posedge clk_i);
    meas(40, 80);
    sleep <= 1'b1;
    run(0, 1, 2);
    run(2, 1, 2);
    conclude();
  end
endmodule // reference_clock_output_bench
`default_nettype wire
